// *** rtl/port_mux_map.svh ***
// Purpose: Register map and fields
// Assumes: 32-bit AXI4-Lite
// Notes:   Shared by the design
`ifndef PORT_MUX_MAP_SVH
`define PORT_MUX_MAP_SVH

`define ADDR_W           8
`define OFF_PORT_B_OUT   8'h00
`define OFF_PORT_B_OE    8'h04
`define OFF_PORT_B_ALT   8'h08
`define OFF_PORT_B_PINS  8'h0C
`define OFF_PORT_C_OUT   8'h10
`define OFF_PORT_C_OE    8'h14
`define OFF_PORT_C_ALT   8'h18
`define OFF_PORT_C_PINS  8'h1C
`define OFF_CTRL         8'h20
`define OFF_STATUS       8'h24

`define CTRL_IRQ0_TYPE   0
`define CTRL_IRQ1_TYPE   1
`define CTRL_T0_CSEL     2
`define CTRL_T1_CSEL     3
`define CTRL_T2_CSEL     4
`define CTRL_CLK_OUT_EN  5
`define CTRL_W           6
`define CTRL_RESET       6'h20

`define STAT_SPEED_STRAP 0
`define STAT_SUSPENDED   1
`define STAT_WAKE_LOW    2
`define STAT_WAKE_EVENT  3

`define PORT_RESET       8'h00
`define CLK_DIV_24M      1'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** rtl/port_mux_pkg.sv ***
// Purpose: Shared types
// Assumes: Constants in the map header
// Notes:   Types only
package port_mux_pkg;
   typedef logic [7:0] port_byte_t;
   typedef enum logic [1:0] {PWR_RUN, PWR_SUSPEND, PWR_WAKE} pwr_state_t;
endpackage

// *** rtl/pin_sync.sv ***
// Purpose: Two-flop pin synchroniser
// Assumes: Inputs asynchronous to sys_clk_i
// Notes:   Only the second stage leaves the module
`timescale 1ns/1ps
module pin_sync #(parameter int W = 8)
(
   input  wire logic         sys_clk_i, // System clock
   input  wire logic         rst_b_i,   // Synchronised reset, active low
   input  wire logic [W-1:0] async_i,   // Raw pin levels
   output logic      [W-1:0] sync_o     // Synchronised levels
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   always_comb
   begin
      meta_next = async_i;
      sync_next = meta_reg;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;
endmodule

// *** rtl/irq_detect.sv ***
// Purpose: Per-pin interrupt request detector, edge or level
// Assumes: Pin already synchronised
// Notes:   Edge mode pulses one cycle
`timescale 1ns/1ps
module irq_detect
(
   input  wire logic sys_clk_i,  // System clock
   input  wire logic rst_b_i,    // Synchronised reset, active low
   input  wire logic enable_i,   // Alternate function selected
   input  wire logic active_hi_i,// Pin polarity: 1 high active
   input  wire logic edge_i,     // 1 edge, 0 level
   input  wire logic pin_i,      // Synchronised pin level
   output logic      req_o       // Request to the core
);
   logic act;
   logic prev_reg;
   logic prev_next;
   logic req_reg;
   logic req_next;

   always_comb
   begin
      act       = active_hi_i ? pin_i : ~pin_i;
      prev_next = act;
      if (!enable_i)
         req_next = 1'b0;
      else if (edge_i)
         req_next = act & ~prev_reg;
      else
         req_next = act;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         prev_reg <= 1'b1;
         req_reg  <= 1'b0;
      end
      else
      begin
         prev_reg <= prev_next;
         req_reg  <= req_next;
      end
   end

   assign req_o = req_reg;
endmodule

// *** rtl/port_b_c_pin_mux.sv ***
// Purpose: Port B and C pin multiplexer
// Assumes: AXI4-Lite, 125 MHz
// Notes:   Pins pass two flops
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "port_mux_map.svh"
module port_b_c_pin_mux
(
   input  wire logic                      sys_clk_i,       // System clock
   input  wire logic                      rst_b_i,         // Reset, active low
   input  wire logic [`ADDR_W-1:0]        s_axi_awaddr,    // Write address
   input  wire logic                      s_axi_awvalid,   // Write address valid
   output logic                           s_axi_awready,   // Write address ready
   input  wire logic [31:0]               s_axi_wdata,     // Write data
   input  wire logic [3:0]                s_axi_wstrb,     // Write strobes
   input  wire logic                      s_axi_wvalid,    // Write data valid
   output logic                           s_axi_wready,    // Write data ready
   output logic [1:0]                     s_axi_bresp,     // Write response
   output logic                           s_axi_bvalid,    // Write response valid
   input  wire logic                      s_axi_bready,    // Write response ready
   input  wire logic [`ADDR_W-1:0]        s_axi_araddr,    // Read address
   input  wire logic                      s_axi_arvalid,   // Read address valid
   output logic                           s_axi_arready,   // Read address ready
   output logic [31:0]                    s_axi_rdata,     // Read data
   output logic [1:0]                     s_axi_rresp,     // Read response
   output logic                           s_axi_rvalid,    // Read valid
   input  wire logic                      s_axi_rready,    // Read ready
   input  wire port_mux_pkg::port_byte_t  port_b_pin_i,    // Port B pin levels
   output port_mux_pkg::port_byte_t       port_b_pin_o,    // Port B pin drive
   output port_mux_pkg::port_byte_t       port_b_pin_oe_o, // Port B drive enable
   input  wire port_mux_pkg::port_byte_t  port_c_pin_i,    // Port C pin levels
   output port_mux_pkg::port_byte_t       port_c_pin_o,    // Port C pin drive
   output port_mux_pkg::port_byte_t       port_c_pin_oe_o, // Port C drive enable
   input  wire logic                      board_test_i,    // Float-all test pin
   input  wire logic                      cpu_speed_strap_i, // High: 12 MHz core
   input  wire logic                      wake_low_pin_i,  // Wake-up pin, low active
   output logic                           clock_out_pin_o, // Clock output pin
   output logic                           clock_out_oe_o,  // Clock output enable
   input  wire logic                      uart1_tx_i,      // Second UART transmit
   input  wire logic                      uart0_tx_i,      // First UART transmit
   input  wire logic                      timer2_overflow_i, // Timer2 overflow pulse
   input  wire logic                      mem_wr_low_i,    // Write strobe, low active
   input  wire logic                      mem_rd_low_i,    // Read strobe, low active
   input  wire logic                      suspend_req_i,   // Core asks to suspend
   output logic                           timer2_count_pin_o,   // Timer2 count input
   output logic                           timer2_trigger_pin_o, // Timer2 trigger input
   output logic                           uart1_rx_pin_o,  // Second UART receive
   output logic                           uart0_rx_pin_o,  // First UART receive
   output logic                           timer0_count_pin_o, // Timer0 count input
   output logic                           timer1_count_pin_o, // Timer1 count input
   output logic                           irq0_req_o,      // Interrupt 0 request
   output logic                           irq1_req_o,      // Interrupt 1 request
   output logic                           irq4_req_o,      // Interrupt 4 request
   output logic                           irq5_req_o,      // Interrupt 5 request
   output logic                           irq6_req_o,      // Interrupt 6 request
   output logic                           wake_irq_o,      // Resume interrupt pulse
   output logic                           osc_run_o,       // Oscillator running
   output logic                           suspended_o,     // Core in suspend
   output logic                           cpu_clk_slow_o   // Core runs at 12 MHz
);
   import port_mux_pkg::*;

   logic [1:0]   rst_sync_reg;
   logic         rst_b;
   port_byte_t   pb_sync;
   port_byte_t   pc_sync;
   logic [2:0]   misc_sync;
   logic         test_s;
   logic         strap_s;
   logic         wake_s;

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_b = rst_sync_reg[1];

   pin_sync #(.W(8)) u_sync_b
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b),
      .async_i   (port_b_pin_i),
      .sync_o    (pb_sync)
   );

   pin_sync #(.W(8)) u_sync_c
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b),
      .async_i   (port_c_pin_i),
      .sync_o    (pc_sync)
   );

   pin_sync #(.W(3)) u_sync_misc
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b),
      .async_i   ({board_test_i, cpu_speed_strap_i, wake_low_pin_i}),
      .sync_o    (misc_sync)
   );
   assign test_s  = misc_sync[2];
   assign strap_s = misc_sync[1];
   assign wake_s  = misc_sync[0];

   port_byte_t        pb_out_reg, pb_out_next, pb_oe_reg, pb_oe_next;
   port_byte_t        pb_alt_reg, pb_alt_next;
   port_byte_t        pc_out_reg, pc_out_next, pc_oe_reg, pc_oe_next;
   port_byte_t        pc_alt_reg, pc_alt_next;
   logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic              wake_evt_reg, wake_evt_next;

   logic              aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [`ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic [31:0]       wdata_reg, wdata_next;
   logic              wstrb0_reg, wstrb0_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   logic              rvalid_reg, rvalid_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic              do_write, wr_hit, rd_hit;
   logic [31:0]       rd_word;
   logic [3:0]        status_word;
   logic              wake_evt_clr;

   pwr_state_t        pwr_reg, pwr_next;
   logic              wake_prev_reg, wake_prev_next;
   logic              wake_fall;

   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign do_write      = aw_hold_reg & w_hold_reg & ~bvalid_reg;

   always_comb
   begin
      status_word = '0;
      status_word[`STAT_SPEED_STRAP] = strap_s;
      status_word[`STAT_SUSPENDED]   = (pwr_reg == PWR_SUSPEND);
      status_word[`STAT_WAKE_LOW]    = ~wake_s;
      status_word[`STAT_WAKE_EVENT]  = wake_evt_reg;
      rd_hit  = 1'b1;
      rd_word = '0;
      case (s_axi_araddr)
         `OFF_PORT_B_OUT:  rd_word = {24'h0, pb_out_reg};
         `OFF_PORT_B_OE:   rd_word = {24'h0, pb_oe_reg};
         `OFF_PORT_B_ALT:  rd_word = {24'h0, pb_alt_reg};
         `OFF_PORT_B_PINS: rd_word = {24'h0, pb_sync};
         `OFF_PORT_C_OUT:  rd_word = {24'h0, pc_out_reg};
         `OFF_PORT_C_OE:   rd_word = {24'h0, pc_oe_reg};
         `OFF_PORT_C_ALT:  rd_word = {24'h0, pc_alt_reg};
         `OFF_PORT_C_PINS: rd_word = {24'h0, pc_sync};
         `OFF_CTRL:        rd_word = {26'h0, ctrl_reg};
         `OFF_STATUS:      rd_word = {28'h0, status_word};
         default:          rd_hit  = 1'b0;
      endcase
   end

   always_comb
   begin
      aw_hold_next = aw_hold_reg;
      w_hold_next  = w_hold_reg;
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      pb_out_next  = pb_out_reg;
      pb_oe_next   = pb_oe_reg;
      pb_alt_next  = pb_alt_reg;
      pc_out_next  = pc_out_reg;
      pc_oe_next   = pc_oe_reg;
      pc_alt_next  = pc_alt_reg;
      ctrl_next    = ctrl_reg;
      wr_hit       = 1'b1;
      wake_evt_clr = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold_next = 1'b1;
         wdata_next  = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
      end
      if (do_write)
      begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         case (awaddr_reg)
            `OFF_PORT_B_OUT: if (wstrb0_reg) pb_out_next = wdata_reg[7:0];
            `OFF_PORT_B_OE:  if (wstrb0_reg) pb_oe_next  = wdata_reg[7:0];
            `OFF_PORT_B_ALT: if (wstrb0_reg) pb_alt_next = wdata_reg[7:0];
            `OFF_PORT_C_OUT: if (wstrb0_reg) pc_out_next = wdata_reg[7:0];
            `OFF_PORT_C_OE:  if (wstrb0_reg) pc_oe_next  = wdata_reg[7:0];
            `OFF_PORT_C_ALT: if (wstrb0_reg) pc_alt_next = wdata_reg[7:0];
            `OFF_CTRL:       if (wstrb0_reg) ctrl_next   = wdata_reg[`CTRL_W-1:0];
            `OFF_STATUS:     wake_evt_clr = wstrb0_reg & wdata_reg[`STAT_WAKE_EVENT];
            `OFF_PORT_B_PINS, `OFF_PORT_C_PINS: wr_hit = 1'b1;
            default:         wr_hit = 1'b0;
         endcase
         bresp_next = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_next = 1'b1;
         rdata_next  = rd_word;
         rresp_next  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_next = 1'b0;
   end

   // Suspend and wake-up control
   always_comb
   begin
      wake_prev_next = wake_s;
      wake_fall      = wake_prev_reg & ~wake_s;
      pwr_next       = pwr_reg;
      case (pwr_reg)
         PWR_RUN:
            if (suspend_req_i && wake_s)
               pwr_next = PWR_SUSPEND;
         PWR_SUSPEND:
            if (wake_fall)
               pwr_next = PWR_WAKE;
         PWR_WAKE:
            pwr_next = PWR_RUN;
         default:
            pwr_next = PWR_RUN;
      endcase
      // Set wins over clear
      wake_evt_next = (pwr_reg == PWR_WAKE) | (wake_evt_reg & ~wake_evt_clr);
   end

   always_ff @(posedge sys_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         wstrb0_reg    <= 1'b0;
         bvalid_reg    <= 1'b0;
         bresp_reg     <= `RESP_OKAY;
         rvalid_reg    <= 1'b0;
         rresp_reg     <= `RESP_OKAY;
         rdata_reg     <= '0;
         pb_out_reg    <= `PORT_RESET;
         pb_oe_reg     <= `PORT_RESET;
         pb_alt_reg    <= `PORT_RESET;
         pc_out_reg    <= `PORT_RESET;
         pc_oe_reg     <= `PORT_RESET;
         pc_alt_reg    <= `PORT_RESET;
         ctrl_reg      <= `CTRL_RESET;
         wake_evt_reg  <= 1'b0;
         pwr_reg       <= PWR_RUN;
         wake_prev_reg <= 1'b1;
      end
      else
      begin
         aw_hold_reg   <= aw_hold_next;
         w_hold_reg    <= w_hold_next;
         awaddr_reg    <= awaddr_next;
         wdata_reg     <= wdata_next;
         wstrb0_reg    <= wstrb0_next;
         bvalid_reg    <= bvalid_next;
         bresp_reg     <= bresp_next;
         rvalid_reg    <= rvalid_next;
         rresp_reg     <= rresp_next;
         rdata_reg     <= rdata_next;
         pb_out_reg    <= pb_out_next;
         pb_oe_reg     <= pb_oe_next;
         pb_alt_reg    <= pb_alt_next;
         pc_out_reg    <= pc_out_next;
         pc_oe_reg     <= pc_oe_next;
         pc_alt_reg    <= pc_alt_next;
         ctrl_reg      <= ctrl_next;
         wake_evt_reg  <= wake_evt_next;
         pwr_reg       <= pwr_next;
         wake_prev_reg <= wake_prev_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp  = rresp_reg;
   assign s_axi_rdata  = rdata_reg;
   assign suspended_o  = (pwr_reg == PWR_SUSPEND);
   assign osc_run_o    = (pwr_reg != PWR_SUSPEND);
   assign wake_irq_o   = (pwr_reg == PWR_WAKE);
   assign cpu_clk_slow_o = strap_s;

   // Core-side inputs, idle when unselected
   assign timer2_count_pin_o   = pb_alt_reg[0] & pb_sync[0] & ctrl_reg[`CTRL_T2_CSEL];
   assign timer2_trigger_pin_o = pb_alt_reg[1] & pb_sync[1];
   assign uart1_rx_pin_o       = pb_alt_reg[2] ? pb_sync[2] : 1'b1;
   assign uart0_rx_pin_o       = pc_alt_reg[0] ? pc_sync[0] : 1'b1;
   assign timer0_count_pin_o   = pc_alt_reg[4] & pc_sync[4] & ctrl_reg[`CTRL_T0_CSEL];
   assign timer1_count_pin_o   = pc_alt_reg[5] & pc_sync[5] & ctrl_reg[`CTRL_T1_CSEL];

   irq_detect u_irq4 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .enable_i(pb_alt_reg[4]),
      .active_hi_i(1'b1), .edge_i(1'b1), .pin_i(pb_sync[4]), .req_o(irq4_req_o));
   irq_detect u_irq5 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .enable_i(pb_alt_reg[5]),
      .active_hi_i(1'b0), .edge_i(1'b1), .pin_i(pb_sync[5]), .req_o(irq5_req_o));
   irq_detect u_irq6 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .enable_i(pb_alt_reg[6]),
      .active_hi_i(1'b1), .edge_i(1'b1), .pin_i(pb_sync[6]), .req_o(irq6_req_o));
   irq_detect u_irq0 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .enable_i(pc_alt_reg[2]),
      .active_hi_i(1'b0), .edge_i(ctrl_reg[`CTRL_IRQ0_TYPE]), .pin_i(pc_sync[2]),
      .req_o(irq0_req_o));
   irq_detect u_irq1 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b), .enable_i(pc_alt_reg[3]),
      .active_hi_i(1'b0), .edge_i(ctrl_reg[`CTRL_IRQ1_TYPE]), .pin_i(pc_sync[3]),
      .req_o(irq1_req_o));

   // Output pin drive, registered
   port_byte_t pb_drv_reg, pb_drv_next, pb_en_reg, pb_en_next;
   port_byte_t pc_drv_reg, pc_drv_next, pc_en_reg, pc_en_next;
   logic       clk_div_reg, clk_div_next, clk_out_reg, clk_out_next;
   port_byte_t pb_alt_drv, pc_alt_drv, pb_alt_out, pc_alt_out;

   always_comb
   begin
      pb_alt_drv = {timer2_overflow_i, 3'h0, uart1_tx_i, 3'h0};
      pb_alt_out = 8'h88;
      pc_alt_drv = {mem_rd_low_i, mem_wr_low_i, 4'h0, uart0_tx_i, 1'b0};
      pc_alt_out = 8'hC2;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         always_comb
         begin
            if (test_s)
            begin
               pb_en_next[gi]  = 1'b0;
               pb_drv_next[gi] = 1'b0;
               pc_en_next[gi]  = 1'b0;
               pc_drv_next[gi] = 1'b0;
            end
            else
            begin
               pb_en_next[gi]  = pb_alt_reg[gi] ? pb_alt_out[gi] : pb_oe_reg[gi];
               pb_drv_next[gi] = pb_alt_reg[gi] ? pb_alt_drv[gi] : pb_out_reg[gi];
               pc_en_next[gi]  = pc_alt_reg[gi] ? pc_alt_out[gi] : pc_oe_reg[gi];
               pc_drv_next[gi] = pc_alt_reg[gi] ? pc_alt_drv[gi] : pc_out_reg[gi];
            end
         end
      end
   endgenerate

   always_comb
   begin
      // Strap high: toggle every second cycle, half rate
      clk_div_next = ~clk_div_reg;
      clk_out_next = (strap_s && clk_div_reg) ? clk_out_reg : ~clk_out_reg;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pb_drv_reg  <= '0;
         pb_en_reg   <= '0;
         pc_drv_reg  <= '0;
         pc_en_reg   <= '0;
         clk_div_reg <= `CLK_DIV_24M;
         clk_out_reg <= 1'b0;
      end
      else
      begin
         pb_drv_reg  <= pb_drv_next;
         pb_en_reg   <= pb_en_next;
         pc_drv_reg  <= pc_drv_next;
         pc_en_reg   <= pc_en_next;
         clk_div_reg <= clk_div_next;
         clk_out_reg <= clk_out_next;
      end
   end

   assign port_b_pin_o    = pb_drv_reg;
   assign port_b_pin_oe_o = pb_en_reg;
   assign port_c_pin_o    = pc_drv_reg;
   assign port_c_pin_oe_o = pc_en_reg;
   assign clock_out_pin_o = clk_out_reg;
   assign clock_out_oe_o  = ctrl_reg[`CTRL_CLK_OUT_EN] & ~test_s;
endmodule

// *** tb/port_mux_properties.sv ***
// Purpose: Port mux timing checks
// Assumes: One clock domain
// Notes:   Bound to the top module
`timescale 1ns/1ps
module port_mux_properties
(
   input wire logic       sys_clk_i,         // Clock
   input wire logic       rst_b_i,           // Reset
   input wire logic [7:0] port_b_pin_i,      // B pins
   input wire logic [7:0] port_b_pin_oe_o,   // B enables
   input wire logic [7:0] port_c_pin_oe_o,   // C enables
   input wire logic       board_test_i,      // Test pin
   input wire logic       clock_out_oe_o,    // Clock enable
   input wire logic       cpu_speed_strap_i, // Strap
   input wire logic       cpu_clk_slow_o,    // Slow core
   input wire logic       irq4_req_o,        // Irq 4
   input wire logic       irq5_req_o,        // Irq 5
   input wire logic       wake_low_pin_i,    // Wake pin
   input wire logic       wake_irq_o,        // Resume irq
   input wire logic       suspended_o        // Suspended
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_float_oe: assert property (board_test_i[*5] |-> !clock_out_oe_o &&
      {port_b_pin_oe_o, port_c_pin_oe_o} == 16'h0000) else $error("pin driven in test");
   a_strap_speed: assert property ($stable(cpu_speed_strap_i)[*8] |->
      cpu_clk_slow_o == cpu_speed_strap_i) else $error("core speed wrong");
   a_irq4_rise: assert property (irq4_req_o |-> $past(port_b_pin_i[4], 3) &&
      !$past(port_b_pin_i[4], 4)) else $error("irq4 without rise");
   a_irq4_once: assert property (irq4_req_o |=> !irq4_req_o) else $error("irq4 long");
   a_irq5_fall: assert property (irq5_req_o |-> !$past(port_b_pin_i[5], 3) &&
      $past(port_b_pin_i[5], 4)) else $error("irq5 without fall");
   a_irq5_once: assert property (irq5_req_o |=> !irq5_req_o) else $error("irq5 long");
   a_wake_resume: assert property (wake_irq_o |=> !wake_irq_o ##1 !suspended_o)
      else $error("no resume");
   a_wake_blocks: assert property (!wake_low_pin_i[*4] |-> !$rose(suspended_o))
      else $error("suspend while wake low");
endmodule
bind port_b_c_pin_mux port_mux_properties u_props (.*);

// *** tb/pin_board.sv ***
// Purpose: Board wiring of one port
// Assumes: Design drive wins
// Notes:   Floating bits toggle, pulled bits read high
`timescale 1ns/1ps
module pin_board #(parameter logic [7:0] PULL = 8'h00)
(
   input  wire logic       clk_i, // Clock
   input  wire logic [7:0] drv_i, // Design level
   input  wire logic [7:0] oe_i,  // Design enable
   input  wire logic [7:0] ext_i, // Bench level
   input  wire logic [7:0] een_i, // Bench enable
   output logic      [7:0] pin_o  // Pin level
);
   logic [7:0] flt_reg = 8'h55;
   always_ff @(posedge clk_i)
      flt_reg <= ~flt_reg;
   assign pin_o = oe_i & drv_i | ~oe_i & (een_i & ext_i | ~een_i & (PULL | flt_reg));
endmodule

// *** tb/port_b_c_pin_mux_tb.sv ***
// Purpose: Bench for the port B and C mux
// Assumes: AXI4-Lite master tasks
// Notes:   Compares at falling edges
`timescale 1ns/1ps
`include "port_mux_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module port_b_c_pin_mux_tb;
   import port_mux_pkg::*;
   logic sys_clk_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, board_test_i, cpu_speed_strap_i, wake_low_pin_i, uart1_tx_i;
   logic uart0_tx_i, timer2_overflow_i, mem_wr_low_i, mem_rd_low_i, suspend_req_i;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic clock_out_pin_o, clock_out_oe_o, timer2_count_pin_o, timer2_trigger_pin_o;
   logic uart1_rx_pin_o, uart0_rx_pin_o, timer0_count_pin_o, timer1_count_pin_o;
   logic irq0_req_o, irq1_req_o, irq4_req_o, irq5_req_o, irq6_req_o, wake_irq_o;
   logic osc_run_o, suspended_o, cpu_clk_slow_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   port_byte_t port_b_pin_i, port_b_pin_o, port_b_pin_oe_o, port_c_pin_i, port_c_pin_o;
   port_byte_t port_c_pin_oe_o, b_ext, c_ext;
   int num_errors, num_checks, cyc;
   port_b_c_pin_mux u_dut (.*);
   pin_board #(.PULL(8'h00)) u_brd_b (.clk_i(sys_clk_i), .drv_i(port_b_pin_o),
      .oe_i(port_b_pin_oe_o), .ext_i(b_ext), .een_i(8'hFF), .pin_o(port_b_pin_i));
   pin_board #(.PULL(8'hC0)) u_brd_c (.clk_i(sys_clk_i), .drv_i(port_c_pin_o),
      .oe_i(port_c_pin_oe_o), .ext_i(c_ext), .een_i(8'h3F), .pin_o(port_c_pin_i));
   always #4 sys_clk_i = ~sys_clk_i;
   task automatic wrap_up();
      $display("[TB] checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
      logic ta, tw, hs;
      @(posedge sys_clk_i);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      hs = 1'h0;
      while (!hs)
      begin
         @(negedge sys_clk_i);
         ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
         tw = s_axi_wvalid & s_axi_wready;
         hs = s_axi_bvalid | s_axi_rvalid;
         if (hs)
            `CHK("resp", e, w ? s_axi_bresp : s_axi_rresp)
         if (hs & !w)
            `CHK("rdata", d, s_axi_rdata)
         @(posedge sys_clk_i);
         if (ta)
            {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
         if (tw)
            s_axi_wvalid <= 1'h0;
         if (hs)
            {s_axi_bready, s_axi_rready} <= 2'h0;
      end
   endtask
   initial
   begin
      {sys_clk_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
       s_axi_rready, board_test_i, cpu_speed_strap_i, uart1_tx_i, uart0_tx_i,
       timer2_overflow_i, suspend_req_i, num_errors, num_checks, cyc} = '0;
      {wake_low_pin_i, mem_wr_low_i, mem_rd_low_i, s_axi_wstrb} = 7'h7F;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, b_ext, c_ext} = {48'h0, 16'h203F};
      repeat (16) @(posedge sys_clk_i);
      rst_b_i <= 1'h1;
      repeat (3) @(negedge sys_clk_i);
      `CHK("oe", 16'h0000, {port_b_pin_oe_o, port_c_pin_oe_o})
      acc(1'h0, `OFF_PORT_B_ALT, 32'h0, `RESP_OKAY);
      acc(1'h0, `OFF_PORT_C_ALT, 32'h0, `RESP_OKAY);
      acc(1'h0, `OFF_CTRL, {26'h0, `CTRL_RESET}, `RESP_OKAY);
      acc(1'h1, 8'h40, 32'h0, `RESP_SLVERR);
      acc(1'h0, 8'h40, 32'h0, `RESP_SLVERR);
      acc(1'h1, `OFF_PORT_B_OUT, 32'hA5, `RESP_OKAY);
      acc(1'h1, `OFF_PORT_B_OE, 32'h0F, `RESP_OKAY);
      repeat (2) @(posedge sys_clk_i);
      acc(1'h0, `OFF_PORT_B_PINS, 32'h25, `RESP_OKAY);
      $display("[TB] io test done");
      acc(1'h1, `OFF_PORT_B_ALT, 32'hFF, `RESP_OKAY);
      acc(1'h1, `OFF_PORT_C_ALT, 32'hFF, `RESP_OKAY);
      acc(1'h1, `OFF_CTRL, 32'h1E, `RESP_OKAY);
      {uart1_tx_i, mem_wr_low_i, b_ext, c_ext} <= {2'h2, 16'h5731};
      repeat (6) @(negedge sys_clk_i);
      `CHK("drive", 32'h88C20880, {port_b_pin_oe_o, port_c_pin_oe_o, port_b_pin_o & 8'h88,
         port_c_pin_o & 8'hC2})
      `CHK("inputs", 9'h1FC, {timer2_count_pin_o, timer2_trigger_pin_o, uart1_rx_pin_o,
         uart0_rx_pin_o, timer0_count_pin_o, timer1_count_pin_o, irq0_req_o, irq1_req_o, clock_out_oe_o})
      acc(1'h1, `OFF_CTRL, 32'h21, `RESP_OKAY);
      repeat (3) @(negedge sys_clk_i);
      `CHK("csel", 5'h01, {timer2_count_pin_o, timer0_count_pin_o, timer1_count_pin_o,
         irq0_req_o, clock_out_oe_o})
      @(posedge sys_clk_i);
      timer2_overflow_i <= 1'h1;
      @(posedge sys_clk_i);
      timer2_overflow_i <= 1'h0;
      @(negedge sys_clk_i);
      `CHK("ovf", 1'h1, port_b_pin_o[7])
      @(negedge sys_clk_i);
      `CHK("ovf", 1'h0, port_b_pin_o[7])
      $display("[TB] alt test done");
      @(posedge sys_clk_i);
      {board_test_i, cpu_speed_strap_i} <= 2'h3;
      repeat (8) @(negedge sys_clk_i);
      `CHK("float", 18'h1, {port_b_pin_oe_o, port_c_pin_oe_o, clock_out_oe_o, cpu_clk_slow_o})
      @(posedge sys_clk_i);
      {board_test_i, wake_low_pin_i} <= 2'h0;
      repeat (3) @(posedge sys_clk_i);
      suspend_req_i <= 1'h1;
      repeat (6) @(negedge sys_clk_i);
      `CHK("blocked", 1'h0, suspended_o)
      @(posedge sys_clk_i);
      wake_low_pin_i <= 1'h1;
      repeat (6) @(negedge sys_clk_i);
      `CHK("sleep", 2'h2, {suspended_o, osc_run_o})
      @(posedge sys_clk_i);
      {wake_low_pin_i, suspend_req_i} <= 2'h0;
      repeat (8) @(negedge sys_clk_i);
      `CHK("resume", 2'h1, {suspended_o, osc_run_o})
      $display("[TB] power test done");
      wrap_up();
   end
endmodule
